// ==== src/irq_prio_fields.sv ====
// Purpose: Two software-visible interrupt priority registers for the arbiter.
// Assumes: Single clock; register port with read data one cycle after strobe.
// Notes: Parameter HAS_CAN selects a variant with the CAN controller.
//
// Notes on behaviour
// - 111 highest, 001 lowest, 000 disables source.
// - First register bits 14:12 change notify.
// - First register bits 10:8 comparator.
// - First register bits 6:4, 2:0 I2C master/slave.
// - Second register bits 6:4, 2:0 SPI2 event/error.
// - Without CAN, both CAN sources stay disabled.
// - Fields reset to 100; unimplemented bits read zero.
//
// Local design decisions: strobed register access and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module irq_prio_fields #(
   parameter bit HAS_CAN = 1'b1
) (
   input wire logic i_clock,
   input wire logic i_rst_n,
   input wire logic [irq_prio_pkg::ADDR_W-1:0] i_addr,
   input wire logic [irq_prio_pkg::DATA_W-1:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   output logic [irq_prio_pkg::DATA_W-1:0] o_rdata,
   output irq_prio_pkg::prio_levels_s o_levels,
   output irq_prio_pkg::prio_enables_s o_enables
);

   logic [15:0] reg0_q, reg0_d;
   logic [15:0] reg1_q, reg1_d;
   logic [15:0] rdata_q, rdata_d;

   // Extracts a level field at a given low bit.
   function automatic logic [2:0] field_at(input logic [15:0] r, input int unsigned pos);
      field_at = r[pos +: 3];
   endfunction

   // Next-value logic for the two registers and the read-data register.
   always_comb begin
      reg0_d = reg0_q;
      reg1_d = reg1_q;
      rdata_d = 16'h0000;
      if (i_wr && i_addr == irq_prio_pkg::OFF_PRIO_CN_CMP_I2C) begin
         reg0_d = i_wdata & irq_prio_pkg::IMPL_MASK;
      end
      if (i_wr && i_addr == irq_prio_pkg::OFF_PRIO_CAN_SPI2) begin
         reg1_d = i_wdata & irq_prio_pkg::IMPL_MASK;
      end
      if (i_rd) begin
         case (i_addr)
            irq_prio_pkg::OFF_PRIO_CN_CMP_I2C: begin
               rdata_d = reg0_q;
            end
            irq_prio_pkg::OFF_PRIO_CAN_SPI2: begin
               rdata_d = reg1_q;
            end
            default: begin
               rdata_d = 16'h0000;
            end
         endcase
      end
   end

   // Registers load level four in every field at reset.
   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         reg0_q <= irq_prio_pkg::REG_RESET;
         reg1_q <= irq_prio_pkg::REG_RESET;
         rdata_q <= 16'h0000;
      end else begin
         reg0_q <= reg0_d;
         reg1_q <= reg1_d;
         rdata_q <= rdata_d;
      end
   end

   assign o_rdata = rdata_q;

   // Levels presented to the arbiter; CAN levels forced off without CAN.
   always_comb begin
      o_levels.change_notify_priority = field_at(reg0_q, irq_prio_pkg::POS_HI_A);
      o_levels.comparator_priority = field_at(reg0_q, irq_prio_pkg::POS_HI_B);
      o_levels.i2c_master_events_priority = field_at(reg0_q, irq_prio_pkg::POS_LO_A);
      o_levels.i2c_slave_events_priority = field_at(reg0_q, irq_prio_pkg::POS_LO_B);
      o_levels.can_event_priority = HAS_CAN ?
         field_at(reg1_q, irq_prio_pkg::POS_HI_A) : irq_prio_pkg::LVL_OFF;
      o_levels.can_rx_ready_priority = HAS_CAN ?
         field_at(reg1_q, irq_prio_pkg::POS_HI_B) : irq_prio_pkg::LVL_OFF;
      o_levels.spi2_event_priority = field_at(reg1_q, irq_prio_pkg::POS_LO_A);
      o_levels.spi2_error_priority = field_at(reg1_q, irq_prio_pkg::POS_LO_B);
   end

   // A level of zero disables its source.
   always_comb begin
      o_enables.change_notify = o_levels.change_notify_priority != irq_prio_pkg::LVL_OFF;
      o_enables.comparator = o_levels.comparator_priority != irq_prio_pkg::LVL_OFF;
      o_enables.i2c_master = o_levels.i2c_master_events_priority != irq_prio_pkg::LVL_OFF;
      o_enables.i2c_slave = o_levels.i2c_slave_events_priority != irq_prio_pkg::LVL_OFF;
      o_enables.can_event = o_levels.can_event_priority != irq_prio_pkg::LVL_OFF;
      o_enables.can_rx_ready = o_levels.can_rx_ready_priority != irq_prio_pkg::LVL_OFF;
      o_enables.spi2_event = o_levels.spi2_event_priority != irq_prio_pkg::LVL_OFF;
      o_enables.spi2_error = o_levels.spi2_error_priority != irq_prio_pkg::LVL_OFF;
   end

   // A read strobe aimed at the first register.
   sequence s_rd_reg0;
      i_rd && (i_addr == irq_prio_pkg::OFF_PRIO_CN_CMP_I2C);
   endsequence

   // A read strobe aimed at the second register.
   sequence s_rd_reg1;
      i_rd && (i_addr == irq_prio_pkg::OFF_PRIO_CAN_SPI2);
   endsequence

   // A read strobe aimed at an index with no register behind it.
   sequence s_rd_unmapped;
      i_rd && (i_addr > irq_prio_pkg::OFF_PRIO_CAN_SPI2);
   endsequence

   // A write to the second register followed by one quiet cycle.
   sequence s_wr_reg1_then_quiet;
      (i_wr && (i_addr == irq_prio_pkg::OFF_PRIO_CAN_SPI2)) ##1 !i_wr;
   endsequence

   // The first register answers with the levels it presents, then the bus drops to zero.
   sequence s_answer_reg0;
      (o_rdata == {1'h0, $past(o_levels.change_notify_priority),
         1'h0, $past(o_levels.comparator_priority),
         1'h0, $past(o_levels.i2c_master_events_priority),
         1'h0, $past(o_levels.i2c_slave_events_priority)}) ##1 (o_rdata == 16'h0000);
   endsequence

   // Zero comparator level must disable the comparator.
   a_zero_disables: assert property (@(posedge i_clock) disable iff (!i_rst_n)
      (o_levels.comparator_priority == 3'h0) |-> !o_enables.comparator)
      else $error("Comparator enabled at level zero.");

   // Every enable is high exactly when its level is non-zero.
   a_enable_levels: assert property (@(posedge i_clock) disable iff (!i_rst_n)
      o_enables == {|o_levels.change_notify_priority, |o_levels.comparator_priority,
         |o_levels.i2c_master_events_priority, |o_levels.i2c_slave_events_priority,
         |o_levels.can_event_priority, |o_levels.can_rx_ready_priority,
         |o_levels.spi2_event_priority, |o_levels.spi2_error_priority})
      else $error("Enable flags disagree with levels.");

   // Change notify level tracks bits 14:12 of a write.
   a_cn_write: assert property (@(posedge i_clock) disable iff (!i_rst_n)
      (i_wr && i_addr == irq_prio_pkg::OFF_PRIO_CN_CMP_I2C) |=>
      o_levels.change_notify_priority == $past(i_wdata[14:12]))
      else $error("Change notify level not updated.");

   // Comparator level tracks bits 10:8.
   a_cmp_write: assert property (@(posedge i_clock) disable iff (!i_rst_n)
      (i_wr && i_addr == irq_prio_pkg::OFF_PRIO_CN_CMP_I2C) |=>
      o_levels.comparator_priority == $past(i_wdata[10:8]))
      else $error("Comparator level not updated.");

   // I2C levels track bits 6:4 and 2:0.
   a_i2c_write: assert property (@(posedge i_clock) disable iff (!i_rst_n)
      (i_wr && i_addr == irq_prio_pkg::OFF_PRIO_CN_CMP_I2C) |=>
      {o_levels.i2c_master_events_priority, o_levels.i2c_slave_events_priority}
      == {$past(i_wdata[6:4]), $past(i_wdata[2:0])})
      else $error("I2C levels not updated.");

   // CAN event level tracks bits 14:12 of the second register when present, else stays off.
   a_can_levels: assert property (@(posedge i_clock) disable iff (!i_rst_n)
      (i_wr && i_addr == irq_prio_pkg::OFF_PRIO_CAN_SPI2) |=>
      o_levels.can_event_priority == (HAS_CAN ? $past(i_wdata[14:12]) : 3'h0))
      else $error("CAN event level wrong.");

   // CAN receive-ready level tracks bits 10:8 when present, else stays off.
   a_can_rx_levels: assert property (@(posedge i_clock) disable iff (!i_rst_n)
      (i_wr && i_addr == irq_prio_pkg::OFF_PRIO_CAN_SPI2) |=>
      o_levels.can_rx_ready_priority == (HAS_CAN ? $past(i_wdata[10:8]) : 3'h0))
      else $error("CAN receive-ready level wrong.");

   // SPI2 levels track bits 6:4 and 2:0.
   a_spi2_write: assert property (@(posedge i_clock) disable iff (!i_rst_n)
      (i_wr && i_addr == irq_prio_pkg::OFF_PRIO_CAN_SPI2) |=>
      {o_levels.spi2_event_priority, o_levels.spi2_error_priority}
      == {$past(i_wdata[6:4]), $past(i_wdata[2:0])})
      else $error("SPI2 levels not updated.");

   // Without CAN both CAN sources are never enabled.
   a_no_can: assert property (@(posedge i_clock) disable iff (!i_rst_n)
      !HAS_CAN |-> !(o_enables.can_event || o_enables.can_rx_ready))
      else $error("CAN source enabled on variant without CAN.");

   // Unimplemented bits always read zero, checked bit by bit.
   a_unimpl_zero: assert property (@(posedge i_clock) disable iff (!i_rst_n)
      {o_rdata[15], o_rdata[11], o_rdata[7], o_rdata[3]} == 4'h0)
      else $error("Unimplemented bits read nonzero.");

   // A read of the second register returns its masked value one cycle later.
   a_read_back: assert property (@(posedge i_clock) disable iff (!i_rst_n)
      (i_rd && i_addr == irq_prio_pkg::OFF_PRIO_CAN_SPI2) |=> o_rdata == $past(reg1_q))
      else $error("Read data mismatch.");

   // The first register reads back the levels it presents, then zero.
   a_read_cn_reg: assert property (@(posedge i_clock) disable iff (!i_rst_n)
      (s_rd_reg0 ##1 !i_rd) |-> s_answer_reg0)
      else $error("First register read back wrong.");

   // A written word comes back masked from the second register.
   a_write_read_back: assert property (@(posedge i_clock) disable iff (!i_rst_n)
      (s_wr_reg1_then_quiet ##1 s_rd_reg1) |=>
      o_rdata == ($past(i_wdata, 3) & irq_prio_pkg::IMPL_MASK))
      else $error("Second register write not read back.");

   // A read of an index with no register returns zero.
   a_read_unmapped: assert property (@(posedge i_clock) disable iff (!i_rst_n)
      s_rd_unmapped |=> o_rdata == 16'h0000)
      else $error("Unmapped read returned data.");

   // Without a read strobe the read data fall back to zero.
   a_idle_read_zero: assert property (@(posedge i_clock) disable iff (!i_rst_n)
      !i_rd |=> o_rdata == 16'h0000)
      else $error("Read data held without a read.");

   // A read leaves every presented level as it was.
   a_read_no_effect: assert property (@(posedge i_clock) disable iff (!i_rst_n)
      i_rd |=> $stable(o_levels))
      else $error("Read changed a level.");

   // A write to an index with no register leaves every level as it was.
   a_unmapped_write: assert property (@(posedge i_clock) disable iff (!i_rst_n)
      (i_wr && i_addr > irq_prio_pkg::OFF_PRIO_CAN_SPI2) |=> $stable(o_levels))
      else $error("Unmapped write changed a level.");

endmodule
`default_nettype wire

// ==== src/irq_prio_pkg.sv ====
// Purpose: Shared constants and types for the interrupt priority field block.
// Assumes: 16-bit register port, two registers at word indices chosen here.
// Notes: Field positions and reset values are common to both registers.
package irq_prio_pkg;
   localparam int unsigned ADDR_W = 4;
   localparam int unsigned DATA_W = 16;
   localparam int unsigned LVL_W = 3;
   // Register offsets on the plain register port.
   localparam logic [3:0] OFF_PRIO_CN_CMP_I2C = 4'h0;
   localparam logic [3:0] OFF_PRIO_CAN_SPI2 = 4'h1;
   // Field low-bit positions within each register.
   localparam int unsigned POS_HI_A = 12;
   localparam int unsigned POS_HI_B = 8;
   localparam int unsigned POS_LO_A = 4;
   localparam int unsigned POS_LO_B = 0;
   // Writable bits; bits 15, 11, 7 and 3 are unimplemented.
   localparam logic [15:0] IMPL_MASK = 16'h7777;
   // Each field resets to level four.
   localparam logic [2:0] LVL_RESET = 3'h4;
   localparam logic [15:0] REG_RESET = 16'h4444;
   localparam logic [2:0] LVL_OFF = 3'h0;

   // Levels handed to the arbitration logic.
   typedef struct packed {
      logic [2:0] change_notify_priority;
      logic [2:0] comparator_priority;
      logic [2:0] i2c_master_events_priority;
      logic [2:0] i2c_slave_events_priority;
      logic [2:0] can_event_priority;
      logic [2:0] can_rx_ready_priority;
      logic [2:0] spi2_event_priority;
      logic [2:0] spi2_error_priority;
   } prio_levels_s;

   // Per-source enable flags.
   typedef struct packed {
      logic change_notify;
      logic comparator;
      logic i2c_master;
      logic i2c_slave;
      logic can_event;
      logic can_rx_ready;
      logic spi2_event;
      logic spi2_error;
   } prio_enables_s;
endpackage

// ==== dv/irq_arb_model.sv ====
// Purpose: Arbiter stand-in that picks the highest enabled level.
// Assumes: Levels and enables come straight from the block.
// Notes: Behavioural; zero means no source can win.
`timescale 1ns/1ps
`default_nettype none
module irq_arb_model (
   input wire irq_prio_pkg::prio_levels_s i_levels,
   input wire irq_prio_pkg::prio_enables_s i_enables,
   output logic [2:0] o_top_level
);
   // A disabled source never wins, and a larger code outranks a smaller one.
   always_comb begin
      o_top_level = 3'h0;
      for (int k = 0; k < 8; k++) begin
         if (i_enables[k] && (i_levels[3*k +: 3] > o_top_level)) begin
            o_top_level = i_levels[3*k +: 3];
         end
      end
   end
endmodule
`default_nettype wire

// ==== dv/irq_prio_fields_tb.sv ====
// Purpose: Self-checking bench for both variants of the priority block.
// Assumes: Reads answer one cycle after the strobe and then return zero.
// Notes: A queue-free reference holds both registers.
`timescale 1ns/1ps
`default_nettype none
module irq_prio_fields_tb;
   logic i_clock = 1'b0;
   logic i_rst_n = 1'b0;
   logic [3:0] i_addr = 4'h0;
   logic [15:0] i_wdata = 16'h0000;
   logic i_wr = 1'b0;
   logic i_rd = 1'b0;
   logic [15:0] rd_a, rd_b;
   irq_prio_pkg::prio_levels_s lv_a, lv_b;
   irq_prio_pkg::prio_enables_s en_a, en_b;
   logic [2:0] top_a;
   logic [15:0] m [2];
   int n_mismatch = 0;
   int tests_run = 0;
   int seed = 32'hd929_d2c3;
   // One variant with the CAN sources and one without.
   irq_prio_fields #(.HAS_CAN(1'b1)) dut_u (.i_clock(i_clock), .i_rst_n(i_rst_n),
      .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(rd_a),
      .o_levels(lv_a), .o_enables(en_a));
   irq_prio_fields #(.HAS_CAN(1'b0)) nocan_u (.i_clock(i_clock), .i_rst_n(i_rst_n),
      .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(rd_b),
      .o_levels(lv_b), .o_enables(en_b));
   irq_arb_model arb_u (.i_levels(lv_a), .i_enables(en_a), .o_top_level(top_a));
   // The clock toggles every 50 ns, a period of 100 ns.
   initial forever #50 i_clock = ~i_clock;
   task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
      tests_run++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
      end
   endtask
   // Levels, enables and the arbiter's pick follow from the reference words.
   task automatic chk_out();
      logic [23:0] e;
      logic [7:0] n;
      logic [2:0] t;
      e = {m[0][14:12], m[0][10:8], m[0][6:4], m[0][2:0],
         m[1][14:12], m[1][10:8], m[1][6:4], m[1][2:0]};
      t = 3'h0;
      for (int k = 0; k < 8; k++) begin
         n[k] = |e[3*k +: 3];
         if (e[3*k +: 3] > t) t = e[3*k +: 3];
      end
      chk(lv_a, e);
      chk({16'h0000, en_a}, {16'h0000, n});
      chk({21'h0, top_a}, {21'h0, t});
      chk(lv_b, e & 24'hff_f03f);
      chk({16'h0000, en_b}, {16'h0000, n & 8'hf3});
   endtask
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge i_clock);
      i_wr <= 1'b1;
      i_addr <= a;
      i_wdata <= d;
      @(posedge i_clock);
      i_wr <= 1'b0;
      if (a < 4'h2) m[a[0]] = d & 16'h7777;
      #1 chk_out();
   endtask
   task automatic rd(input logic [3:0] a);
      @(posedge i_clock);
      i_rd <= 1'b1;
      i_addr <= a;
      @(posedge i_clock);
      i_rd <= 1'b0;
      #1 chk({8'h00, rd_a}, {8'h00, (a < 4'h2) ? m[a[0]] : 16'h0000});
      chk({8'h00, rd_b}, {8'h00, (a < 4'h2) ? m[a[0]] : 16'h0000});
      @(posedge i_clock);
      #1 chk({8'h00, rd_a}, 24'h0);
      chk({8'h00, rd_b}, 24'h0);
   endtask
   task automatic do_reset();
      @(posedge i_clock);
      i_rst_n <= 1'b0;
      repeat (12) @(posedge i_clock);
      i_rst_n <= 1'b1;
      m[0] = 16'h4444;
      m[1] = 16'h4444;
      #1 chk_out();
   endtask
   task automatic final_report();
      $display("mismatches %0d of %0d compares", n_mismatch, tests_run);
      if (n_mismatch == 0 && tests_run > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   // Reset values, every level code with spare bits set, random traffic, reset again.
   initial begin
      logic [31:0] r;
      do_reset();
      rd(4'h0);
      rd(4'h1);
      for (int v = 0; v < 8; v++) begin
         wr(4'h0, {4{1'b1, v[2:0]}});
         wr(4'h1, {4{1'b1, v[2:0]}});
      end
      rd(4'h1);
      for (int i = 0; i < 300; i++) begin
         r = $random(seed);
         if (r[31]) wr(r[3:0] & (r[4] ? 4'hf : 4'h1), r[21:6]);
         else rd(r[3:0] & (r[4] ? 4'hf : 4'h1));
      end
      do_reset();
      rd(4'h1);
      final_report();
   end
endmodule
`default_nettype wire
